// file: pdirq_port.v
// One port's shared power-down input / interrupt output pin and its registers
//
// Notes on behaviour
// [R1] Reset: pin is power-down input, irq off
// [R2] Output enable bit makes pin irq output
// [R3] Low input pin powers the port down
// [R4] Weak pull-up; outside may pull low
// [R5] Registers stay accessible while powered down
// [R6] Output enable ignores pin as power-down
// [R7] Each port has its own pin
// [R8] All interrupt sources disabled after reset
// [R9] Irq enable plus mask gate sources
// [R10] Irq drives pin low without clock
// [R11] Status byte shows every pending cause
// [R12] Status read clears flags, pin releases
// [R13] 0003h and 0060h enable example sources
// [R14] Host reads each port on shared line
// [R15] Energy detect idle keeps low power
// [R16] Line activity runs normal power-up
// [R17] Energy detect periodically sends pulses
// [R18] Energy detect control register at 1Dh
// [R19] Page select register; page 2 diagnostics
// [R20] Pin input synchronised before power-down
`timescale 1ns/1ps
`include "pdirq_defs.vh"
module pdirq_port (
   input  wire        clk_sys_i,
   input  wire        rst_n_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   input  wire [4:0]  reg_addr_i,
   input  wire [15:0] reg_wdata_i,
   output reg  [15:0] reg_rdata_o,
   input  wire [7:0]  irq_event_i,
   input  wire        line_energy_i,
   input  wire        pin_i,
   output wire        pin_o,
   output wire        pin_oe_n_o,
   output wire        power_down_o,
   output wire        energy_low_power_o,
   output wire        energy_pulse_o,
   output wire        diag_page_o
);
   // ---------------------------------------------------------------
   // Energy-detect states
   // ---------------------------------------------------------------
   localparam [1:0] ST_AWAKE = 2'b00;
   localparam [1:0] ST_SLEEP = 2'b01;
   localparam [1:0] ST_WAKE  = 2'b10;

   // ---------------------------------------------------------------
   // Storage and internal nets
   // ---------------------------------------------------------------
   // Next-value regs are combinational; the flops are the _r names and reg_rdata_o
   reg  [15:0] mode_r;
   reg  [15:0] mode_nxt;
   reg  [15:0] ictl_r;
   reg  [15:0] ictl_nxt;
   reg  [7:0]  mask_r;
   reg  [7:0]  mask_nxt;
   reg  [7:0]  flags_r;
   reg  [7:0]  flags_nxt;
   reg  [15:0] page_r;
   reg  [15:0] page_nxt;
   reg  [15:0] edc_r;
   reg  [15:0] edc_nxt;
   reg  [15:0] rdata_nxt;
   reg  [15:0] pulse_cnt_r;
   reg  [15:0] pulse_cnt_nxt;
   reg         pulse_r;
   reg         pulse_nxt;
   reg  [1:0]  nrg_state_r;
   reg  [1:0]  nrg_state_nxt;
   reg         sleep_r;
   reg         sleep_nxt;
   wire        pin_sync;
   wire        int_oe;
   wire        int_en;
   wire        nrg_en;
   wire        pin_pd;
   wire        irq_pending;
   wire        rd_status;
   wire        wr_mode;
   wire        wr_ictl;
   wire        wr_mask;
   wire        wr_page;
   wire        wr_edc;
   wire [7:0]  ev_gated;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   // Address match, shared by the write and read paths
   function hit;
      input [4:0] addr;
      input [4:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   // Status read doubles as the flag clear strobe
   assign rd_status = reg_rd_i & hit(reg_addr_i, `PDIRQ_ADDR_ISM_OFS);
   assign wr_mode   = reg_wr_i & hit(reg_addr_i, `PDIRQ_ADDR_MODE_OFS);
   assign wr_ictl   = reg_wr_i & hit(reg_addr_i, `PDIRQ_ADDR_ICTL_OFS);
   assign wr_mask   = reg_wr_i & hit(reg_addr_i, `PDIRQ_ADDR_ISM_OFS);
   assign wr_page   = reg_wr_i & hit(reg_addr_i, `PDIRQ_ADDR_PAGE_OFS);
   assign wr_edc    = reg_wr_i & hit(reg_addr_i, `PDIRQ_ADDR_EDC_OFS);

   // ---------------------------------------------------------------
   // Pin input path
   // ---------------------------------------------------------------
   // Agreement filter drops glitches shorter than a clock period
   pdirq_sync u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .d_i       (pin_i),
      .q_o       (pin_sync)
   ); // [R20]

   assign int_oe = ictl_r[`PDIRQ_ICTL_OE_BIT]; // [R1] [R2]
   assign int_en = ictl_r[`PDIRQ_ICTL_EN_BIT]; // [R9]

   // Pin only counts as power-down while it is not an output [R3] [R6]
   assign pin_pd = ~int_oe & ~pin_sync;
   // Register bit acts in every mode, the pin only as an input; either one powers the port down
   assign power_down_o = mode_r[`PDIRQ_MODE_PWRDN_BIT] | pin_pd; // [R3]

   // ---------------------------------------------------------------
   // Interrupt flags
   // ---------------------------------------------------------------
   assign ev_gated = irq_event_i & mask_r; // [R8] [R9]

   // Only enabled sources latch; a fresh event wins over a read clear
   always @* begin
      flags_nxt = flags_r | ev_gated; // [R11]
      if (rd_status) begin
         flags_nxt = ev_gated; // [R12]
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flags_r <= `PDIRQ_RST_FLAGS;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // Raw event is ORed in so the pin falls without a clock edge
   assign irq_pending = int_en & (|flags_r | |ev_gated); // [R9] [R10]
   // Open-drain style: drive low only; enable low while driving [R4]
   assign pin_o      = 1'b0;
   assign pin_oe_n_o = ~(int_oe & irq_pending); // [R2] [R10] [R7]

   // ---------------------------------------------------------------
   // Register next values
   // ---------------------------------------------------------------
   // Registers stay live regardless of power-down [R5]
   always @* begin
      mode_nxt = mode_r;
      if (wr_mode) begin
         mode_nxt = reg_wdata_i; // [R3]
      end
   end

   always @* begin
      ictl_nxt = ictl_r;
      if (wr_ictl) begin
         ictl_nxt = reg_wdata_i; // [R13]
      end
   end

   always @* begin
      mask_nxt = mask_r;
      if (wr_mask) begin
         mask_nxt = reg_wdata_i[7:0]; // [R13]
      end
   end

   always @* begin
      page_nxt = page_r;
      if (wr_page) begin
         page_nxt = reg_wdata_i; // [R19]
      end
   end

   always @* begin
      edc_nxt = edc_r;
      if (wr_edc) begin
         edc_nxt = reg_wdata_i; // [R18]
      end
   end

   assign diag_page_o = (page_r == `PDIRQ_PAGE_DIAG); // [R19]

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_r <= `PDIRQ_RST_MODE;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ictl_r <= `PDIRQ_RST_ICTL; // [R1]
      end else begin
         ictl_r <= ictl_nxt;
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_r <= `PDIRQ_RST_MASK; // [R8]
      end else begin
         mask_r <= mask_nxt;
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         page_r <= `PDIRQ_RST_PAGE;
      end else begin
         page_r <= page_nxt;
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         edc_r <= `PDIRQ_RST_EDC;
      end else begin
         edc_r <= edc_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Register reads
   // ---------------------------------------------------------------
   // Unmapped addresses read as zero; data holds until the next read
   always @* begin
      rdata_nxt = reg_rdata_o;
      if (reg_rd_i) begin
         if (hit(reg_addr_i, `PDIRQ_ADDR_MODE_OFS)) begin
            rdata_nxt = mode_r;
         end else if (hit(reg_addr_i, `PDIRQ_ADDR_ICTL_OFS)) begin
            rdata_nxt = ictl_r;
         end else if (hit(reg_addr_i, `PDIRQ_ADDR_ISM_OFS)) begin
            rdata_nxt = {flags_r, mask_r}; // [R11]
         end else if (hit(reg_addr_i, `PDIRQ_ADDR_PAGE_OFS)) begin
            rdata_nxt = page_r;
         end else if (hit(reg_addr_i, `PDIRQ_ADDR_EDC_OFS)) begin
            rdata_nxt = edc_r; // [R18]
         end else begin
            rdata_nxt = 16'h0000;
         end
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 16'h0000;
      end else begin
         reg_rdata_o <= rdata_nxt; // [R5]
      end
   end

   // ---------------------------------------------------------------
   // Energy detect
   // ---------------------------------------------------------------
   assign nrg_en = edc_r[`PDIRQ_EDC_EN_BIT];

   // Sleep while enabled and quiet; activity restarts normal power-up
   always @* begin
      nrg_state_nxt = nrg_state_r;
      case (nrg_state_r)
         ST_AWAKE: begin
            if (nrg_en && !line_energy_i) begin
               nrg_state_nxt = ST_SLEEP; // [R15]
            end
         end
         ST_SLEEP: begin
            if (!nrg_en) begin
               nrg_state_nxt = ST_AWAKE;
            end else if (line_energy_i) begin
               nrg_state_nxt = ST_WAKE; // [R16]
            end
         end
         // One-cycle step stands for the power-up sequence
         ST_WAKE: begin
            nrg_state_nxt = ST_AWAKE; // [R16]
         end
         default: begin
            nrg_state_nxt = ST_AWAKE;
         end
      endcase
      sleep_nxt = (nrg_state_nxt == ST_SLEEP); // [R15]
   end

   // Pulse timer runs in every state while energy detect is enabled; clearing the enable stops the pulses
   // Count ends one short so pulses come exactly a period apart
   always @* begin
      pulse_cnt_nxt = pulse_cnt_r + 16'h0001;
      pulse_nxt     = 1'b0;
      if (!nrg_en) begin
         pulse_cnt_nxt = 16'h0000;
      end else if (pulse_cnt_r == `PDIRQ_NRG_PULSE_CYC - 16'h0001) begin
         pulse_cnt_nxt = 16'h0000;
         pulse_nxt     = 1'b1; // [R17]
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nrg_state_r <= ST_AWAKE;
         sleep_r     <= 1'b0;
      end else begin
         nrg_state_r <= nrg_state_nxt;
         sleep_r     <= sleep_nxt;
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse_cnt_r <= 16'h0000;
         pulse_r     <= 1'b0;
      end else begin
         pulse_cnt_r <= pulse_cnt_nxt;
         pulse_r     <= pulse_nxt;
      end
   end

   assign energy_low_power_o = sleep_r; // [R15]
   assign energy_pulse_o     = pulse_r; // [R17]
endmodule // pdirq_port

// file: pdirq_defs.vh
// Register offsets, field positions and reset values for the power-down/irq pin logic
`ifndef PDIRQ_DEFS_VH
`define PDIRQ_DEFS_VH
`define PDIRQ_ADDR_MODE_OFS     5'h00
`define PDIRQ_ADDR_ICTL_OFS     5'h11
`define PDIRQ_ADDR_ISM_OFS      5'h12
`define PDIRQ_ADDR_PAGE_OFS     5'h13
`define PDIRQ_ADDR_EDC_OFS      5'h1D
`define PDIRQ_MODE_PWRDN_BIT    11
`define PDIRQ_ICTL_OE_BIT       0
`define PDIRQ_ICTL_EN_BIT       1
`define PDIRQ_EDC_EN_BIT        15
`define PDIRQ_ISM_LINK_BIT      5
`define PDIRQ_ISM_ENERGY_BIT    6
`define PDIRQ_PAGE_DIAG         16'h0002
`define PDIRQ_RST_MODE          16'h0000
`define PDIRQ_RST_FLAGS         8'h00
`define PDIRQ_RST_ICTL          16'h0000
`define PDIRQ_RST_MASK          8'h00
`define PDIRQ_RST_PAGE          16'h0000
`define PDIRQ_RST_EDC           16'h0000
`define PDIRQ_NRG_PULSE_CYC     16'h4E20
`endif

// file: pdirq_sync.v
// Three-stage synchroniser with agreement filter for an asynchronous pin
`timescale 1ns/1ps
module pdirq_sync (
   input  wire clk_sys_i,
   input  wire rst_n_i,
   input  wire d_i,
   output wire q_o
);
   reg s1_r;
   reg s2_r;
   reg s3_r;
   reg q_r;

   // Pin idles high through its pull-up, so reset to high
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
         q_r  <= 1'b1;
      end else begin
         s1_r <= d_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            q_r <= s3_r;
         end
      end
   end

   assign q_o = q_r;
endmodule // pdirq_sync

// file: pdirq_asserts.sv
// Port-level checker for the power-down / interrupt pin block
`timescale 1ns/1ps
module pdirq_asserts (
   input wire        clk_sys_i,
   input wire        rst_n_i,
   input wire        reg_wr_i,
   input wire        reg_rd_i,
   input wire [4:0]  reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire [15:0] reg_rdata_o,
   input wire [7:0]  irq_event_i,
   input wire        pin_i,
   input wire        pin_o,
   input wire        pin_oe_n_o,
   input wire        power_down_o,
   input wire        energy_pulse_o,
   input wire        diag_page_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_clr_rd;
      reg_rd_i && reg_addr_i == 5'h12 && irq_event_i == 8'h00;
   endsequence
   a_pin_drive: assert property (pin_o == 1'b0) else $error("pin high");
   a_read_clear: assert property (
      s_clr_rd |=> (|irq_event_i) || pin_oe_n_o) else $error("no clear");
   a_pin_release: assert property (
      $rose(pin_oe_n_o) |-> $past(reg_rd_i)) else $error("early release");
   a_irq_async: assert property (
      $fell(pin_oe_n_o) |-> |irq_event_i) else $error("late irq");
   a_pd_cause: assert property (
      $rose(power_down_o) |-> $past(reg_wr_i) || !$past(pin_i, 2))
      else $error("stray power-down");
   a_rdata_hold: assert property (
      !reg_rd_i |=> $stable(reg_rdata_o)) else $error("rdata moved");
   a_page_sel: assert property (
      reg_wr_i && reg_addr_i == 5'h13 |=>
      diag_page_o == ($past(reg_wdata_i) == 16'h0002)) else $error("page");
   a_pulse_one: assert property (
      energy_pulse_o |=> !energy_pulse_o) else $error("long pulse");
endmodule // pdirq_asserts
bind pdirq_port pdirq_asserts u_chk (.*);

// file: pdirq_host.sv
// Host-side model of the shared pin with its weak pull-up
`timescale 1ns/1ps
module pdirq_host (
   input  wire pin_oe_n_o,
   input  wire host_low_i,
   output wire pin_i
);
   assign pin_i = !pin_oe_n_o ? 1'b0 : !host_low_i;
endmodule // pdirq_host

// file: tb_top.sv
// Bench for one port: register tasks, pin and energy-detect checks
`timescale 1ns/1ps
module tb_top;
   reg  clk_sys_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   reg  line_energy_i = 1'b0, host_low_i = 1'b1;
   reg  [4:0]  reg_addr_i = 5'h00;
   reg  [15:0] reg_wdata_i = 16'h0000;
   reg  [7:0]  irq_event_i = 8'h00;
   wire [15:0] reg_rdata_o;
   wire pin_i, pin_o, pin_oe_n_o, power_down_o, energy_pulse_o;
   wire diag_page_o, energy_low_power_o;
   integer bad_count = 0, cmp_count = 0;
   pdirq_port dut (.*);
   pdirq_host host (.*);
   initial forever #25 clk_sys_i = ~clk_sys_i;
   initial #3000000 begin
      bad_count = bad_count + 1;
      end_sim;
   end
   task chk(input [15:0] g, input [15:0] e);
      cmp_count = cmp_count + 1;
      bad_count = bad_count + (g !== e);
      if (g !== e) $display("BAD %0t got %h want %h", $time, g, e);
   endtask
   task acc(input w, input [4:0] a, input [15:0] d);
      @(negedge clk_sys_i);
      {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = {a, d, w, !w};
      @(negedge clk_sys_i);
      {reg_wr_i, reg_rd_i} = 2'b00;
      if (!w) chk(reg_rdata_o, d);
   endtask
   task end_sim;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Pin held low by the host from the start: port comes up powered down
   initial begin
      #800 rst_n_i = 1'b1;
      acc(1'b0, 5'h11, 16'h0000);
      acc(1'b0, 5'h12, 16'h0000);
      #100 chk({power_down_o, pin_oe_n_o}, 2'b11);
      chk(pin_o, 1'b0);
      acc(1'b1, 5'h11, 16'h0003);
      acc(1'b1, 5'h12, 16'h0060);
      irq_event_i = 8'h20;
      #1 chk({power_down_o, pin_oe_n_o}, 2'b00);
      @(negedge clk_sys_i) irq_event_i = 8'h01;
      @(negedge clk_sys_i) irq_event_i = 8'h00;
      acc(1'b0, 5'h12, 16'h2060);
      chk(pin_oe_n_o, 1'b1);
      acc(1'b1, 5'h13, 16'h0002);
      acc(1'b1, 5'h1D, 16'h8000);
      repeat (25000) if (energy_pulse_o !== 1'b1) @(negedge clk_sys_i);
      chk({energy_pulse_o, energy_low_power_o, diag_page_o}, 3'h7);
      line_energy_i = 1'b1;
      #400 chk(energy_low_power_o, 1'b0);
      end_sim;
   end
endmodule // tb_top
